// ===== design/qbp_map.svh
// Function
// - After reset every upper-address port pin is high, held only by the weak pullup.
// - After reset every alternate-function port pin is latched to one and held by the weak pullup.
// - A pin in the weak-pullup high state acts as an input that any outside driver may override.
// - Writing zero to a pin turns on the strong pulldown until a one is written or reset occurs.
// - Writing one to a pin that was zero gives a brief strong pull-high, then the weak pullup.
// - The upper-address port can carry the high byte of the external address bus.
// - Alternate bits 0 and 1 are serial 0 receive and transmit, bits 2 and 3 external interrupts.
// - Alternate bits 4 and 5 are the external count inputs of timer 0 and timer 1.
// - Alternate bit 6 is the external data write strobe and bit 7 the read strobe.
// - The active-low external-access input selects external program fetch when low.
// - One machine cycle takes four input clocks.
// - Timers advance once per twelve clocks by default, or once per four clocks when selected.
`ifndef QBP_MAP_SVH
`define QBP_MAP_SVH
`define QBP_PORT_RESET    8'hff
`define QBP_MC_CLOCKS     4'h4
`define QBP_TMR_SLOW      4'hc
`define QBP_KICK_CLOCKS   2'h2
`define QBP_BIT_RXD       0
`define QBP_BIT_TXD       1
`define QBP_BIT_IRQ0      2
`define QBP_BIT_IRQ1      3
`define QBP_BIT_TCNT0     4
`define QBP_BIT_TCNT1     5
`define QBP_BIT_WR        6
`define QBP_BIT_RD        7
`endif

// ===== design/qbp_pkg.sv
package qbp_pkg;
    // Pin drive state of one quasi-bidirectional cell
    typedef enum logic [1:0] {
        QBP_WEAK_HIGH = 2'b00,
        QBP_KICK_HIGH = 2'b01,
        QBP_PULL_LOW  = 2'b11
    } qbp_drive_type;
endpackage : qbp_pkg

// ===== design/qbp_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
`include "qbp_map.svh"
module qbp_pin_cell
    import qbp_pkg::*;
(
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    // Wanted level and pad level
    input  wire logic i_level,
    input  wire logic i_pad,
    // Pad drive
    output logic      o_strong_low,
    output logic      o_strong_high,
    output logic      o_weak_high,
    output logic      o_sample
);
    qbp_drive_type state_reg;
    qbp_drive_type state_next;
    logic [1:0]    kick_reg;
    logic [1:0]    kick_next;
    logic [2:0]    sync_reg;
    logic          sample_reg;

    // Drive state: zero pulls hard low, a rising level kicks high briefly
    always_comb begin
        state_next = state_reg;
        kick_next  = kick_reg;
        case (state_reg)
            QBP_WEAK_HIGH: begin
                if (!i_level) state_next = QBP_PULL_LOW;
            end
            QBP_PULL_LOW: begin
                if (i_level) begin
                    state_next = QBP_KICK_HIGH;
                    kick_next  = `QBP_KICK_CLOCKS;
                end
            end
            QBP_KICK_HIGH: begin
                if (!i_level) state_next = QBP_PULL_LOW;
                else if (kick_reg <= 2'h1) state_next = QBP_WEAK_HIGH;
                kick_next = kick_reg - 2'h1;
            end
            default: state_next = QBP_WEAK_HIGH;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= QBP_WEAK_HIGH;
            kick_reg  <= 2'h0;
        end else begin
            state_reg <= state_next;
            kick_reg  <= kick_next;
        end
    end

    // Three-stage sampler; a change counts once the last two agree
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync_reg   <= 3'h7;
            sample_reg <= 1'b1;
        end else begin
            sync_reg <= {sync_reg[1:0], i_pad};
            if (sync_reg[2] == sync_reg[1]) sample_reg <= sync_reg[2];
        end
    end

    assign o_strong_low  = (state_reg == QBP_PULL_LOW);
    assign o_strong_high = (state_reg == QBP_KICK_HIGH);
    assign o_weak_high   = (state_reg != QBP_PULL_LOW); // Weak pullup is the input state
    assign o_sample      = sample_reg;
endmodule : qbp_pin_cell
`default_nettype wire

// ===== design/qbp_ports.sv
`timescale 1ns/1ps
`default_nettype none
`include "qbp_map.svh"
module qbp_ports
    import qbp_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    // Core-side port latch writes
    input  wire logic       i_p2_we,
    input  wire logic [7:0] i_p2_wdata,
    input  wire logic       i_p3_we,
    input  wire logic [7:0] i_p3_wdata,
    // External bus use of the upper-address port
    input  wire logic       i_ext_bus_active,
    input  wire logic [7:0] i_upper_address_byte,
    // Alternate outputs, each active while its enable is set
    input  wire logic       i_serial0_transmit_out,
    input  wire logic       i_serial0_tx_en,
    input  wire logic       i_xdata_wr_n,
    input  wire logic       i_xdata_rd_n,
    input  wire logic       i_xdata_strobe_en,
    // Timer speed select, one bit per timer
    input  wire logic [1:0] i_timer_fast,
    // Strap and pads
    input  wire logic       i_external_access_n,
    input  wire logic [7:0] i_p2_pad,
    input  wire logic [7:0] i_p3_pad,
    // Pad drive
    output logic [7:0]      o_p2_strong_low,
    output logic [7:0]      o_p2_strong_high,
    output logic [7:0]      o_p2_weak_high,
    output logic [7:0]      o_p3_strong_low,
    output logic [7:0]      o_p3_strong_high,
    output logic [7:0]      o_p3_weak_high,
    // Core-side read data and timing
    output logic [7:0]      o_p2_rdata,
    output logic [7:0]      o_p3_rdata,
    output logic [7:0]      o_p3_latch,
    output logic            o_serial0_receive_in,
    output logic            o_ext_irq_zero_in,
    output logic            o_ext_irq_one_in,
    output logic            o_timer_zero_count_in,
    output logic            o_timer_one_count_in,
    output logic            o_fetch_external,
    output logic            o_machine_cycle,
    output logic [1:0]      o_timer_tick
);
    logic [7:0] p2_latch_reg;
    logic [7:0] p3_latch_reg;
    logic [7:0] p2_level;
    logic [7:0] p3_level;
    logic [7:0] p2_sample;
    logic [7:0] p3_sample;
    logic [7:0] p2_sl, p2_sh, p2_wh, p3_sl, p3_sh, p3_wh;
    logic [3:0] mc_cnt_reg;
    logic [3:0] slow_cnt_reg;
    logic [2:0] ea_sync_reg;
    logic       ea_reg;
    logic       ea_seen_reg;
    logic [2:0] ea_fill_reg;
    logic       ea_take;
    wire  [1:0] tick_sel;
    wire        mc_wrap   = (mc_cnt_reg == `QBP_MC_CLOCKS - 4'h1);
    wire        slow_wrap = (slow_cnt_reg == `QBP_TMR_SLOW - 4'h1);

    // Port latches; both reset to all ones
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            p2_latch_reg <= `QBP_PORT_RESET;
            p3_latch_reg <= `QBP_PORT_RESET;
        end else begin
            if (i_p2_we) p2_latch_reg <= i_p2_wdata;
            if (i_p3_we) p3_latch_reg <= i_p3_wdata;
        end
    end

    // Address byte overrides the latch while the bus runs
    assign p2_level = i_ext_bus_active ? i_upper_address_byte : p2_latch_reg;

    // Alternate outputs AND with the latch; software keeps the latch at one to use them
    always_comb begin
        p3_level = p3_latch_reg;
        if (i_serial0_tx_en) begin
            p3_level[`QBP_BIT_TXD] = p3_latch_reg[`QBP_BIT_TXD] & i_serial0_transmit_out;
        end
        if (i_xdata_strobe_en) begin
            p3_level[`QBP_BIT_WR] = p3_latch_reg[`QBP_BIT_WR] & i_xdata_wr_n;
            p3_level[`QBP_BIT_RD] = p3_latch_reg[`QBP_BIT_RD] & i_xdata_rd_n;
        end
    end

    // One cell per pin of each port
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_pin
            qbp_pin_cell u_p2 (
                .i_clk         (i_clk),
                .i_rst_b       (i_rst_b),
                .i_level       (p2_level[g]),
                .i_pad         (i_p2_pad[g]),
                .o_strong_low  (p2_sl[g]),
                .o_strong_high (p2_sh[g]),
                .o_weak_high   (p2_wh[g]),
                .o_sample      (p2_sample[g])
            );
            qbp_pin_cell u_p3 (
                .i_clk         (i_clk),
                .i_rst_b       (i_rst_b),
                .i_level       (p3_level[g]),
                .i_pad         (i_p3_pad[g]),
                .o_strong_low  (p3_sl[g]),
                .o_strong_high (p3_sh[g]),
                .o_weak_high   (p3_wh[g]),
                .o_sample      (p3_sample[g])
            );
        end
    endgenerate

    // Machine-cycle and timer prescalers
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mc_cnt_reg   <= 4'h0;
            slow_cnt_reg <= 4'h0;
        end else begin
            mc_cnt_reg   <= mc_wrap ? 4'h0 : mc_cnt_reg + 4'h1;
            slow_cnt_reg <= slow_wrap ? 4'h0 : slow_cnt_reg + 4'h1;
        end
    end

    // The sampler's reset value is no pin level, so wait until all three stages hold samples
    assign ea_take = ea_fill_reg[2] && !ea_seen_reg && (ea_sync_reg[2] == ea_sync_reg[1]);

    // Strap sampled after reset release through three flops, then held
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ea_sync_reg <= 3'h7;
            ea_fill_reg <= 3'h0;
            ea_reg      <= 1'b1;
            ea_seen_reg <= 1'b0;
        end else begin
            ea_sync_reg <= {ea_sync_reg[1:0], i_external_access_n};
            ea_fill_reg <= {ea_fill_reg[1:0], 1'b1};
            if (ea_take) begin
                ea_reg      <= ea_sync_reg[2];
                ea_seen_reg <= 1'b1;
            end
        end
    end

    // Per-timer rate select; software may mix a fast and a slow timer
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_tick
            assign tick_sel[g] = i_timer_fast[g] ? mc_wrap : slow_wrap;
        end
    endgenerate

    // Pad drive, one cycle behind the cell state
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_p2_strong_low  <= 8'h00;
            o_p2_strong_high <= 8'h00;
            o_p2_weak_high   <= 8'hff;
            o_p3_strong_low  <= 8'h00;
            o_p3_strong_high <= 8'h00;
            o_p3_weak_high   <= 8'hff;
        end else begin
            o_p2_strong_low  <= p2_sl;
            o_p2_strong_high <= p2_sh;
            o_p2_weak_high   <= p2_wh;
            o_p3_strong_low  <= p3_sl;
            o_p3_strong_high <= p3_sh;
            o_p3_weak_high   <= p3_wh;
        end
    end

    // Read data follows the pins, not the latches
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_p2_rdata <= 8'hff;
            o_p3_rdata <= 8'hff;
            o_p3_latch <= 8'hff;
        end else begin
            o_p2_rdata <= p2_sample;
            o_p3_rdata <= p3_sample;
            o_p3_latch <= p3_latch_reg;
        end
    end

    // Alternate inputs share the filtered samples, so they lag the pins like a port read
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_serial0_receive_in  <= 1'b1;
            o_ext_irq_zero_in     <= 1'b1;
            o_ext_irq_one_in      <= 1'b1;
            o_timer_zero_count_in <= 1'b1;
            o_timer_one_count_in  <= 1'b1;
        end else begin
            o_serial0_receive_in  <= p3_sample[`QBP_BIT_RXD];
            o_ext_irq_zero_in     <= p3_sample[`QBP_BIT_IRQ0];
            o_ext_irq_one_in      <= p3_sample[`QBP_BIT_IRQ1];
            o_timer_zero_count_in <= p3_sample[`QBP_BIT_TCNT0];
            o_timer_one_count_in  <= p3_sample[`QBP_BIT_TCNT1];
        end
    end

    // Timing strobes and the held strap
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_fetch_external <= 1'b0;
            o_machine_cycle  <= 1'b0;
            o_timer_tick     <= 2'h0;
        end else begin
            o_fetch_external <= ea_seen_reg & ~ea_reg;
            o_machine_cycle  <= mc_wrap;
            o_timer_tick     <= tick_sel;
        end
    end
endmodule : qbp_ports
`default_nettype wire

// ===== testbench/qbp_ports_props.sv
`timescale 1ns/1ps
`default_nettype none
module qbp_ports_props (
    // Watched ports
    input wire logic       i_clk,
    input wire logic       i_rst_b,
    input wire logic       i_p2_we,
    input wire logic [7:0] i_p2_wdata,
    input wire logic       i_ext_bus_active,
    input wire logic [7:0] i_upper_address_byte,
    input wire logic       i_serial0_transmit_out,
    input wire logic       i_serial0_tx_en,
    input wire logic [1:0] i_timer_fast,
    input wire logic [7:0] i_p3_pad,
    input wire logic [7:0] o_p2_strong_low,
    input wire logic [7:0] o_p2_strong_high,
    input wire logic [7:0] o_p2_weak_high,
    input wire logic [7:0] o_p3_strong_low,
    input wire logic [7:0] o_p3_strong_high,
    input wire logic [7:0] o_p3_rdata,
    input wire logic [7:0] o_p3_latch,
    input wire logic       o_ext_irq_zero_in,
    input wire logic       o_machine_cycle,
    input wire logic [1:0] o_timer_tick
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // The kick is a fixed two-clock burst, then the weak pullup alone
    sequence s_kick;
        o_p2_strong_high[0] [*2] ##1 !o_p2_strong_high[0];
    endsequence
    // Same burst on the write strobe pin when it returns high
    sequence s_strobe_kick;
        o_p3_strong_high[6] [*2] ##1 !o_p3_strong_high[6];
    endsequence
    // Pads must sit still long enough to pass the synchroniser
    sequence s_pad_still;
        $stable(i_p3_pad) [*7];
    endsequence
    a_zero_pulls_low: assert property (i_p2_we && !i_p2_wdata[0] |-> ##[1:3] o_p2_strong_low[0])
        else $error("pulldown missing after zero write");
    a_low_not_weak: assert property (!(|(o_p2_strong_low & o_p2_weak_high)))
        else $error("weak pullup on while pulled low");
    a_kick_brief: assert property ($rose(o_p2_strong_high[0]) |-> s_kick)
        else $error("strong pull-high length wrong");
    a_strobe_kick: assert property ($rose(o_p3_strong_high[6]) |-> s_strobe_kick)
        else $error("strobe pin pull-high length wrong");
    a_pad_read_back: assert property (s_pad_still |-> o_p3_rdata == i_p3_pad
        && o_ext_irq_zero_in == i_p3_pad[2])
        else $error("read data differs from pad");
    a_addr_on_pins: assert property (($stable(i_upper_address_byte) && i_ext_bus_active) [*4]
        |-> o_p2_strong_low == ~i_upper_address_byte)
        else $error("upper address byte not on pins");
    a_tx_drives_pin: assert property ((i_serial0_tx_en && !i_serial0_transmit_out
        && o_p3_latch[1]) [*4] |-> o_p3_strong_low[1])
        else $error("transmit low not on pin");
    a_cycle_of_four: assert property ($rose(o_machine_cycle)
        |=> !o_machine_cycle [*3] ##1 o_machine_cycle)
        else $error("machine cycle not four clocks");
    a_tick_slow: assert property (o_timer_tick[0] && !i_timer_fast[0]
        |=> !o_timer_tick[0] [*8] ##1 !o_timer_tick[0] [*3] ##1 o_timer_tick[0])
        else $error("slow timer tick not twelve clocks");
    a_tick_fast: assert property (o_timer_tick[1] && i_timer_fast[1]
        |=> !o_timer_tick[1] [*3] ##1 o_timer_tick[1])
        else $error("fast timer tick not four clocks");
endmodule : qbp_ports_props
bind qbp_ports qbp_ports_props u_props (.i_clk, .i_rst_b, .i_p2_we, .i_p2_wdata, .i_ext_bus_active,
    .i_upper_address_byte, .i_serial0_transmit_out, .i_serial0_tx_en, .i_timer_fast, .i_p3_pad,
    .o_p2_strong_low, .o_p2_strong_high, .o_p2_weak_high, .o_p3_strong_low, .o_p3_strong_high,
    .o_p3_rdata, .o_p3_latch, .o_ext_irq_zero_in, .o_machine_cycle, .o_timer_tick);
`default_nettype wire

// ===== testbench/qbp_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module qbp_pad_model (
    // Clock
    input  wire logic       i_clk,
    // Device drive and outside driver
    input  wire logic [7:0] i_strong_low,
    input  wire logic [7:0] i_strong_high,
    input  wire logic [7:0] i_weak_high,
    input  wire logic [7:0] i_ext_en,
    input  wire logic [7:0] i_ext_val,
    // Resolved pad level
    output logic [7:0]      o_pad
);
    logic [7:0] last_reg;
    logic [7:0] level;
    logic [7:0] floating;
    // Outside driver beats the weak pullup, never the strong drivers
    assign level = ~i_strong_low & (i_strong_high | (i_ext_en & i_ext_val)
        | (~i_ext_en & i_weak_high));
    // An undriven pad wanders rather than keeping a stale level
    assign floating = ~(i_strong_low | i_strong_high | i_weak_high | i_ext_en);
    assign o_pad = (level & ~floating) | (~last_reg & floating);
    // Last pad level
    always_ff @(posedge i_clk) begin
        last_reg <= o_pad;
    end
endmodule : qbp_pad_model
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct {logic p; logic [7:0] d; logic [7:0] low;} qbp_row_type;
    logic       i_clk = 0, i_rst_b = 0, i_p2_we = 0, i_p3_we = 0, i_ext_bus_active = 0;
    logic       i_serial0_transmit_out = 1, i_serial0_tx_en = 0, i_xdata_wr_n = 1;
    logic       i_xdata_rd_n = 1, i_xdata_strobe_en = 0, i_external_access_n = 0;
    logic [7:0] i_p2_wdata = 8'hff, i_p3_wdata = 8'hff, i_upper_address_byte = 8'h00;
    logic [7:0] p3_ext_en = 8'h00;
    logic [1:0] i_timer_fast = 2'h2;
    wire logic [7:0] i_p2_pad, i_p3_pad, o_p2_strong_low, o_p2_strong_high, o_p2_weak_high;
    wire logic [7:0] o_p3_strong_low, o_p3_strong_high, o_p3_weak_high, o_p2_rdata;
    wire logic [7:0] o_p3_rdata, o_p3_latch;
    wire logic       o_serial0_receive_in, o_ext_irq_zero_in, o_ext_irq_one_in, o_machine_cycle;
    wire logic       o_timer_zero_count_in, o_timer_one_count_in, o_fetch_external;
    wire logic [1:0] o_timer_tick;
    int failures = 0, check_count = 0, n, mc, t0, t1;
    qbp_row_type rows[4] = '{'{1'b0, 8'h00, 8'hff}, '{1'b0, 8'ha5, 8'h5a},
                            '{1'b1, 8'h3c, 8'hc3}, '{1'b1, 8'hff, 8'h00}};
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
    qbp_ports dut (.*);
    qbp_pad_model u_p2 (.i_clk, .i_strong_low(o_p2_strong_low), .i_strong_high(o_p2_strong_high),
        .i_weak_high(o_p2_weak_high), .i_ext_en(8'h00), .i_ext_val(8'h00), .o_pad(i_p2_pad));
    qbp_pad_model u_p3 (.i_clk, .i_strong_low(o_p3_strong_low), .i_strong_high(o_p3_strong_high),
        .i_weak_high(o_p3_weak_high), .i_ext_en(p3_ext_en), .i_ext_val(8'h00), .o_pad(i_p3_pad));
    // Free-running core clock
    always #5 i_clk = ~i_clk;
    // One-cycle latch write on either port
    task automatic wr(input logic p, input logic [7:0] d);
        @(negedge i_clk);
        i_p3_we = p;
        i_p2_we = !p;
        i_p2_wdata = d;
        i_p3_wdata = d;
        @(negedge i_clk);
        i_p2_we = 0;
        i_p3_we = 0;
    endtask : wr
    // Reset with the strap tied to one level, as a board would
    task automatic do_reset(input logic ea);
        i_external_access_n = ea;
        i_rst_b = 0;
        repeat (8) @(negedge i_clk);
        `CHK({o_p2_weak_high, o_p2_strong_low, o_p2_strong_high}, 24'hff0000)
        `CHK({o_p3_latch, o_p3_weak_high, o_p3_strong_low}, 24'hffff00)
        i_rst_b = 1;
        repeat (8) @(negedge i_clk); // Strap settles through the sampler first
        `CHK(o_fetch_external, !ea)
    endtask : do_reset
    // Count strobes over 48 clocks, a whole number of both timer periods
    task automatic count_window;
        mc = 0;
        t0 = 0;
        t1 = 0;
        repeat (48) begin
            @(negedge i_clk);
            mc += (o_machine_cycle === 1'b1);
            t0 += (o_timer_tick[0] === 1'b1);
            t1 += (o_timer_tick[1] === 1'b1);
        end
    endtask : count_window
    task automatic conclude;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    initial begin
        do_reset(1'b0);
        foreach (rows[i]) begin
            wr(rows[i].p, rows[i].d);
            repeat (8) @(negedge i_clk);
            `CHK(rows[i].p ? o_p3_strong_low : o_p2_strong_low, rows[i].low)
            `CHK(rows[i].p ? o_p3_weak_high : o_p2_weak_high, ~rows[i].low)
            `CHK(rows[i].p ? o_p3_rdata : o_p2_rdata, rows[i].d)
        end
        // Back-to-back zero then one: the kick lasts two clocks
        wr(1'b0, 8'h00);
        wr(1'b0, 8'hff);
        n = 0;
        repeat (6) begin
            @(negedge i_clk);
            if (o_p2_strong_high[0] === 1'b1) n++;
        end
        `CHK(n, 2)
        `CHK(o_p2_weak_high, 8'hff)
        // Outside drivers override high pins
        p3_ext_en = 8'h15;
        repeat (8) @(negedge i_clk);
        `CHK(o_p3_rdata, 8'hea)
        `CHK({o_serial0_receive_in, o_ext_irq_zero_in, o_ext_irq_one_in}, 3'b001)
        `CHK({o_timer_zero_count_in, o_timer_one_count_in}, 2'b01)
        p3_ext_en = 8'h00;
        // Alternate outputs own their pins while the latch stays one
        {i_serial0_tx_en, i_serial0_transmit_out, i_xdata_strobe_en, i_xdata_wr_n} = 4'ha;
        {i_ext_bus_active, i_upper_address_byte} = 9'h13c;
        repeat (8) @(negedge i_clk);
        `CHK({o_p3_latch, o_p3_strong_low}, 16'hff42)
        `CHK(o_p2_strong_low, 8'hc3)
        {i_xdata_wr_n, i_xdata_rd_n} = 2'h2;
        repeat (8) @(negedge i_clk);
        `CHK(o_p3_strong_low, 8'h82)
        {i_serial0_tx_en, i_xdata_strobe_en, i_ext_bus_active} = 3'h0;
        // Machine cycle and both timer rates over a whole window
        count_window();
        `CHK(mc, 12)
        `CHK({t0, t1}, {32'd4, 32'd12})
        // A reset right after a zero write, before the pulldown turns on; the timer rates swap across it
        wr(1'b0, 8'h00);
        i_timer_fast = 2'h1;
        do_reset(1'b1);
        count_window();
        `CHK(mc, 12)
        `CHK({t0, t1}, {32'd12, 32'd4})
        conclude();
    end
endmodule : testbench
`default_nettype wire
